//--- common/fws_regs.vh
// constants for the flash write status and unlock sequencer
`ifndef FWS_REGS_VH
`define FWS_REGS_VH
`define FWS_ADDR_UNLOCK1 16'h5555
`define FWS_ADDR_UNLOCK2 16'h2aaa
`define FWS_DATA_AA 8'haa
`define FWS_DATA_55 8'h55
`define FWS_CMD_PROGRAM 8'ha0
`define FWS_CMD_ERASE 8'h80
`define FWS_CMD_SECTOR 8'h30
`define FWS_CMD_BLOCK 8'h50
`define FWS_CMD_CHIP 8'h10
`define FWS_CMD_ID_ENTRY 8'h90
`define FWS_CMD_ID_EXIT 8'hf0
`define FWS_POLL_BIT 7
`define FWS_TOGGLE_BIT 6
`define FWS_CLK_PERIOD_PS 4000
`define FWS_GLITCH_NS 5
`define FWS_GLITCH_CYCLES ((`FWS_GLITCH_NS*1000+`FWS_CLK_PERIOD_PS-1)/`FWS_CLK_PERIOD_PS)
`define FWS_SETTLE_NS 1000
`define FWS_SETTLE_CYCLES ((`FWS_SETTLE_NS*1000+`FWS_CLK_PERIOD_PS-1)/`FWS_CLK_PERIOD_PS)
`define FWS_PROGRAM_CYCLES 4000
`define FWS_ERASE_CYCLES 8000
`endif

//--- src/fws_strobe_filter.v
// write strobe synchroniser with glitch rejection
module fws_strobe_filter #(
  parameter MIN_LOW = 2
)(
  input wire clk,
  input wire rst,
  input wire strobeIn_n,
  output reg strobeRise
);
  reg sync1;
  reg sync2;
  reg [7:0] lowCount;
  reg armed;
  always @(posedge clk)
  begin
    if (rst)
    begin
      sync1 <= 1'b1;
      sync2 <= 1'b1;
      lowCount <= 8'h00;
      armed <= 1'b0;
      strobeRise <= 1'b0;
    end
    else
    begin
      sync1 <= strobeIn_n;
      sync2 <= sync1;
      strobeRise <= 1'b0;
      if (!sync2)
      begin
        if (lowCount != 8'hff)
          lowCount <= lowCount + 8'h01;
        if (lowCount >= MIN_LOW[7:0] - 8'h01)
          armed <= 1'b1; // R8
      end
      else
      begin
        lowCount <= 8'h00;
        armed <= 1'b0;
        strobeRise <= armed; // R8
      end
    end
  end
endmodule

//--- src/fws_busy_timer.v
// countdown for the internal program or erase time
module fws_busy_timer #(
  parameter WIDTH = 24
)(
  input wire clk,
  input wire rst,
  input wire start,
  input wire [WIDTH-1:0] load,
  output reg busy,
  output reg done
);
  reg [WIDTH-1:0] count;
  always @(posedge clk)
  begin
    if (rst)
    begin
      count <= {WIDTH{1'b0}};
      busy <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start && !busy)
      begin
        count <= load;
        busy <= 1'b1;
      end
      else if (busy)
      begin
        if (count == {WIDTH{1'b0}} || count == {{(WIDTH-1){1'b0}}, 1'b1})
        begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        else
          count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule

//--- src/fws_sequencer.v
// command decoder and end-of-write status for the flash write path
// Notes on behaviour
// R1: while programming, reads give inverted written bit 7; true value after
// R2: other bits may lag bit 7; host waits 1 us before trusting byte
// R3: during erase bit 7 reads 0, and 1 once erase finishes
// R4: status valid after 4th strobe rise (program) or 6th (erase)
// R5: host polls only at addresses inside the valid memory range
// R6: each read during program or erase flips bit 6
// R7: on completion bit 6 stops flipping and next operation is accepted
// R8: strobe low pulses shorter than 5 ns are rejected as glitches
// R9: output gate low with strobe high inhibits all writes
// R10: program needs AA@5555, 55@2AAA, A0@5555, then location and data
// R11: erase needs AA,55,80,AA,55 then 30 sector or 50 block
// R12: chip erase ends 10@5555 and is accepted only in parallel mode
// R13: id entry AA,55,90; exit by single F0 or three-write F0 alike
// R14: id mode returns maker code at zero, device code at one
// R15: host issues command writes as consecutive cycles
// R16: upper address bits of unlock writes are don't-care in parallel mode
// R17: commands written while busy are ignored
// R18: host rereads twice when a status read seems to conflict
// R19: any mismatching unlock write returns decoder to idle
// R20: while busy reads give status bits whatever the address
`include "fws_regs.vh"
module fws_sequencer #(
  parameter ADDR_WIDTH = 19,
  parameter MAKER_CODE = 8'h5a,  // arbitrary value
  parameter DEVICE_CODE = 8'ha5, // arbitrary value
  parameter PROGRAM_CYCLES = `FWS_PROGRAM_CYCLES,
  parameter ERASE_CYCLES = `FWS_ERASE_CYCLES,
  parameter SETTLE_CYCLES = `FWS_SETTLE_CYCLES
)(
  input wire clk,
  input wire rst,
  input wire parallelProgrammingMode,
  input wire writeStrobe_n,
  input wire outputGate_n,
  input wire readStrobe,
  input wire [ADDR_WIDTH-1:0] address,
  input wire [7:0] writeData,
  input wire [7:0] arrayData,
  output reg [7:0] readData,
  output reg readValid,
  output reg busy,
  output reg dataSettled,
  output reg arrayProgram,
  output reg arrayEraseSector,
  output reg arrayEraseBlock,
  output reg arrayEraseChip,
  output reg [ADDR_WIDTH-1:0] arrayAddress,
  output reg [7:0] arrayWriteData,
  output reg idMode
);
  localparam S_IDLE = 3'd0;
  localparam S_GOT1 = 3'd1;
  localparam S_GOT2 = 3'd2;
  localparam S_PROG = 3'd3;
  localparam S_ERASE3 = 3'd4;
  localparam S_ERASE4 = 3'd5;
  localparam S_ERASE5 = 3'd6;

  // strobe, gate, mode and read pins come from outside: two flops before use
  reg gateSync1;
  reg gateSync2;
  reg modeSync1;
  reg modeSync2;
  reg rdSync1;
  reg rdSync2;
  reg rdPrev;
  reg [2:0] state;
  reg [2:0] next_state;
  reg eraseKind;
  reg [7:0] latchedData;
  reg toggle;
  reg [15:0] settleCount;
  reg startProgram;
  reg startErase;
  reg startSector;
  reg startBlock;
  reg startChip;
  reg next_idMode;
  wire strobeRise;
  wire timerBusy;
  wire timerDone;
  wire writeTaken;
  wire [15:0] lowAddr;
  wire readEdge;
  wire [23:0] loadValue;

  fws_strobe_filter #(
    .MIN_LOW(`FWS_GLITCH_CYCLES)
  ) uFilter (
    .clk(clk),
    .rst(rst),
    .strobeIn_n(writeStrobe_n),
    .strobeRise(strobeRise)
  );

  assign loadValue = startProgram ? PROGRAM_CYCLES[23:0] : ERASE_CYCLES[23:0];

  fws_busy_timer #(
    .WIDTH(24)
  ) uTimer (
    .clk(clk),
    .rst(rst),
    .start(startProgram | startErase),
    .load(loadValue),
    .busy(timerBusy),
    .done(timerDone)
  );

  // R16: only the low sixteen address bits take part in decoding
  assign lowAddr = address[15:0];
  // R9: a rising strobe seen while the gate is low is not a write
  assign writeTaken = strobeRise && gateSync2;
  assign readEdge = rdSync2 && !rdPrev;

  always @(posedge clk)
  begin
    if (rst)
    begin
      gateSync1 <= 1'b1;
      gateSync2 <= 1'b1;
      modeSync1 <= 1'b0;
      modeSync2 <= 1'b0;
      rdSync1 <= 1'b0;
      rdSync2 <= 1'b0;
      rdPrev <= 1'b0;
    end
    else
    begin
      gateSync1 <= outputGate_n;
      gateSync2 <= gateSync1;
      modeSync1 <= parallelProgrammingMode;
      modeSync2 <= modeSync1;
      rdSync1 <= readStrobe;
      rdSync2 <= rdSync1;
      rdPrev <= rdSync2;
    end
  end

  always @*
  begin
    next_state = state;
    next_idMode = idMode;
    startProgram = 1'b0;
    startErase = 1'b0;
    startSector = 1'b0;
    startBlock = 1'b0;
    startChip = 1'b0;
    if (writeTaken && !timerBusy && !busy) // R17
    begin
      next_state = S_IDLE; // R19
      case (state)
        S_IDLE:
        begin
          if (lowAddr == `FWS_ADDR_UNLOCK1 && writeData == `FWS_DATA_AA)
            next_state = S_GOT1;
          else if (writeData == `FWS_CMD_ID_EXIT)
            next_idMode = 1'b0; // R13
        end
        S_GOT1:
        begin
          if (lowAddr == `FWS_ADDR_UNLOCK2 && writeData == `FWS_DATA_55)
            next_state = S_GOT2;
        end
        S_GOT2:
        begin
          if (lowAddr == `FWS_ADDR_UNLOCK1)
          begin
            case (writeData)
              `FWS_CMD_PROGRAM: next_state = S_PROG; // R10
              `FWS_CMD_ERASE: next_state = S_ERASE3; // R11
              `FWS_CMD_ID_ENTRY: next_idMode = 1'b1; // R13
              `FWS_CMD_ID_EXIT: next_idMode = 1'b0; // R13
              default: next_state = S_IDLE;
            endcase
          end
        end
        S_PROG:
          startProgram = 1'b1; // R10
        S_ERASE3:
        begin
          if (lowAddr == `FWS_ADDR_UNLOCK1 && writeData == `FWS_DATA_AA)
            next_state = S_ERASE4;
        end
        S_ERASE4:
        begin
          if (lowAddr == `FWS_ADDR_UNLOCK2 && writeData == `FWS_DATA_55)
            next_state = S_ERASE5;
        end
        S_ERASE5:
        begin
          if (writeData == `FWS_CMD_SECTOR)
            startSector = 1'b1; // R11
          else if (writeData == `FWS_CMD_BLOCK)
            startBlock = 1'b1; // R11
          else if (writeData == `FWS_CMD_CHIP &&
                   lowAddr == `FWS_ADDR_UNLOCK1 && modeSync2)
            startChip = 1'b1; // R12
          startErase = startSector | startBlock | startChip;
        end
        default:
          next_state = S_IDLE;
      endcase
    end
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      state <= S_IDLE;
      idMode <= 1'b0;
      eraseKind <= 1'b0;
      latchedData <= 8'h00;
      busy <= 1'b0;
      arrayProgram <= 1'b0;
      arrayEraseSector <= 1'b0;
      arrayEraseBlock <= 1'b0;
      arrayEraseChip <= 1'b0;
      arrayAddress <= {ADDR_WIDTH{1'b0}};
      arrayWriteData <= 8'h00;
    end
    else
    begin
      state <= next_state;
      idMode <= next_idMode;
      arrayProgram <= startProgram;
      arrayEraseSector <= startSector;
      arrayEraseBlock <= startBlock;
      arrayEraseChip <= startChip;
      // R4: status reporting begins right after the final strobe rise
      busy <= (startProgram | startErase) | (timerBusy & !timerDone);
      if (startProgram | startErase)
      begin
        eraseKind <= startErase;
        latchedData <= writeData;
        arrayAddress <= address;
        arrayWriteData <= writeData;
      end
    end
  end

  // R2: flag that tells the host the whole byte is trustworthy again
  always @(posedge clk)
  begin
    if (rst)
    begin
      settleCount <= 16'h0000;
      dataSettled <= 1'b1;
    end
    else if (startProgram | startErase)
    begin
      settleCount <= 16'h0000;
      dataSettled <= 1'b0;
    end
    else if (!busy && !dataSettled)
    begin
      if (settleCount >= SETTLE_CYCLES[15:0] - 16'h0001)
        dataSettled <= 1'b1;
      else
        settleCount <= settleCount + 16'h0001;
    end
  end

  // read path; status bits come out whatever the address while busy
  always @(posedge clk)
  begin
    if (rst)
    begin
      readData <= 8'h00;
      readValid <= 1'b0;
      toggle <= 1'b0;
    end
    else
    begin
      readValid <= readEdge;
      if (readEdge)
      begin
        if (busy) // R20
        begin
          toggle <= ~toggle; // R6
          readData <= arrayData;
          readData[`FWS_TOGGLE_BIT] <= toggle; // R6
          if (eraseKind)
            readData[`FWS_POLL_BIT] <= 1'b0; // R3
          else
            readData[`FWS_POLL_BIT] <= ~latchedData[`FWS_POLL_BIT]; // R1
        end
        else if (idMode)
        begin
          // R14: addresses other than the two codes read as zero
          if (address == {ADDR_WIDTH{1'b0}})
            readData <= MAKER_CODE;
          else if (address == {{(ADDR_WIDTH-1){1'b0}}, 1'b1})
            readData <= DEVICE_CODE;
          else
            readData <= 8'h00;
        end
        else
          readData <= arrayData; // R7
      end
    end
  end
endmodule

//--- testbench/fws_sequencer_properties.sv
// port checker for the flash write sequencer
module fws_sequencer_properties #(
  parameter PROGRAM_CYCLES = 4000,
  parameter ERASE_CYCLES = 8000,
  parameter SETTLE_CYCLES = 250
)(
  input wire clk,
  input wire rst,
  input wire parallelProgrammingMode,
  input wire readStrobe,
  input wire [7:0] readData,
  input wire readValid,
  input wire busy,
  input wire dataSettled,
  input wire arrayProgram,
  input wire arrayEraseSector,
  input wire arrayEraseBlock,
  input wire arrayEraseChip,
  input wire [7:0] arrayWriteData
);
  wire anyErase = arrayEraseSector | arrayEraseBlock | arrayEraseChip;
  wire anyOp = arrayProgram | anyErase;
  reg [15:0] busyCount;
  reg [15:0] settleCount;
  reg eraseOp;
  reg progBit;
  reg seenRead;
  reg lastBit;
  always @(posedge clk)
  begin
    busyCount <= busy ? busyCount + 16'h0001 : 16'h0000;
    settleCount <= (busy || dataSettled) ? 16'h0000 : settleCount + 16'h0001;
    seenRead <= busy && !rst && (seenRead || readValid);
    if (readValid)
      lastBit <= readData[6];
    if (rst || anyErase)
      eraseOp <= !rst;
    else if (arrayProgram)
      eraseOp <= 1'b0;
    if (arrayProgram)
      progBit <= arrayWriteData[7];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_start;
    ##[0:1] busy;
  endsequence
  sequence s_answer;
    ##[2:5] readValid;
  endsequence
  a_busy_follows:
    assert property (anyOp |-> s_start) else $error("no busy after start");
  a_pulse_once:
    assert property (anyOp |=> !anyOp) else $error("start pulse too long");
  a_ignore_busy:
    assert property ($past(busy, 2) && busy |-> !anyOp)
    else $error("operation started while busy");
  a_chip_parallel:
    assert property (arrayEraseChip |-> $past(parallelProgrammingMode, 3))
    else $error("chip erase outside parallel mode");
  a_busy_span:
    assert property ($fell(busy) |-> busyCount >= PROGRAM_CYCLES - 1
      && busyCount <= ERASE_CYCLES + 1) else $error("busy length wrong");
  a_settle_time:
    assert property ($rose(dataSettled) |-> settleCount >= SETTLE_CYCLES - 1
      && settleCount <= SETTLE_CYCLES + 1) else $error("settle time wrong");
  a_read_answer:
    assert property ($rose(readStrobe) |-> s_answer)
    else $error("read not answered");
  a_toggle_flip:
    assert property (busy && readValid && seenRead |-> readData[6] != lastBit)
    else $error("status bit 6 did not alternate");
  a_poll_erase:
    assert property (busy && readValid && eraseOp |-> !readData[7])
    else $error("bit 7 not low during erase");
  a_poll_program:
    assert property (busy && readValid && !eraseOp |-> readData[7] == !progBit)
    else $error("bit 7 not inverted during program");
endmodule
bind fws_sequencer fws_sequencer_properties #(
  .PROGRAM_CYCLES(PROGRAM_CYCLES),
  .ERASE_CYCLES(ERASE_CYCLES),
  .SETTLE_CYCLES(SETTLE_CYCLES)
) u_chk (.clk, .rst, .parallelProgrammingMode, .readStrobe, .readData,
  .readValid, .busy, .dataSettled, .arrayProgram, .arrayEraseSector,
  .arrayEraseBlock, .arrayEraseChip, .arrayWriteData);

//--- testbench/fws_array_model.sv
// behavioural flash array behind the sequencer's array port
module fws_array_model (
  input logic clk,
  input logic [18:0] address,
  input logic [18:0] arrayAddress,
  input logic [7:0] arrayWriteData,
  input logic arrayProgram,
  input logic arrayErase,
  output logic [7:0] arrayData
);
  timeunit 1ns;
  timeprecision 1ps;
  // only the low address byte is stored; any erase clears the whole model
  logic [7:0] mem [0:255];
  initial
  begin
    foreach (mem[i])
      mem[i] = 8'hff;
  end
  always @(posedge clk)
  begin
    if (arrayErase)
      foreach (mem[i])
        mem[i] <= 8'hff;
    else if (arrayProgram)
      mem[arrayAddress[7:0]] <= mem[arrayAddress[7:0]] & arrayWriteData;
  end
  assign arrayData = mem[address[7:0]];
endmodule

//--- testbench/tb_top.sv
// self-checking bench for the flash write sequencer
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [18:0] U1 = 19'h05555;
  localparam logic [18:0] U2 = 19'h02aaa;
  logic clk = 0, rst = 1, parallelProgrammingMode = 1, writeStrobe_n = 1;
  logic outputGate_n = 1, readStrobe = 0, idMode, readValid, busy;
  logic dataSettled, arrayProgram, arrayEraseSector, arrayEraseBlock;
  logic arrayEraseChip;
  logic [18:0] address = 0, arrayAddress;
  logic [7:0] writeData = 0, arrayData, readData, arrayWriteData, rv;
  int fails = 0, samples_checked = 0, cycles = 0;
  logic [2:0] eraseKindSeen = 3'h0;
  always #2 clk = ~clk;
  // remembers which erase pulse the array port carried last
  always @(posedge clk)
  begin
    if (arrayEraseSector | arrayEraseBlock | arrayEraseChip)
      eraseKindSeen <= {arrayEraseChip, arrayEraseBlock, arrayEraseSector};
  end
  // maker and device codes are arbitrary values
  fws_sequencer #(.MAKER_CODE(8'h5a), .DEVICE_CODE(8'ha5),
    .PROGRAM_CYCLES(200), .ERASE_CYCLES(300), .SETTLE_CYCLES(5))
  u_dut (.clk, .rst, .parallelProgrammingMode, .writeStrobe_n, .outputGate_n,
    .readStrobe, .address, .writeData, .arrayData, .readData, .readValid,
    .busy, .dataSettled, .arrayProgram, .arrayEraseSector, .arrayEraseBlock,
    .arrayEraseChip, .arrayAddress, .arrayWriteData, .idMode);
  fws_array_model u_arr (.clk, .address, .arrayAddress, .arrayWriteData,
    .arrayProgram, .arrayErase(arrayEraseSector | arrayEraseBlock |
    arrayEraseChip), .arrayData);
  task automatic print_verdict;
    if (fails == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] got, exp);
    samples_checked++;
    if (got !== exp)
    begin
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
      fails++;
    end
  endtask
  // strobe held low lowLen cycles; address and data held well past the rise
  task automatic wr(input logic [18:0] a, input logic [7:0] d, int lowLen);
    @(posedge clk);
    address <= a;
    writeData <= d;
    writeStrobe_n <= 0;
    repeat (lowLen) @(posedge clk);
    writeStrobe_n <= 1;
    repeat (8) @(posedge clk);
  endtask
  task automatic rd(input logic [18:0] a);
    int n = 0;
    @(posedge clk);
    address <= a;
    readStrobe <= 1;
    while (readValid !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    rv = readData;
    readStrobe <= 0;
    chk("readValid", {7'h0, readValid}, 8'h01);
    repeat (4) @(posedge clk);
  endtask
  task automatic cmd3(input logic [7:0] c);
    wr(U1, 8'haa, 3);
    wr(U2, 8'h55, 3);
    wr(U1, c, 3);
  endtask
  task automatic erase(input logic [7:0] c, input logic [18:0] a);
    cmd3(8'h80);
    wr(U1, 8'haa, 3);
    wr(U2, 8'h55, 3);
    wr(a, c, 3);
  endtask
  task automatic chkBusy(input logic b);
    chk("busy", {7'h0, busy}, {7'h0, b});
  endtask
  task automatic waitIdle;
    int n = 0;
    while ((busy !== 1'b0 || dataSettled !== 1'b1) && n < 600)
    begin
      @(posedge clk);
      n++;
    end
    chkBusy(0);
    chk("settled", {7'h0, dataSettled}, 8'h01);
  endtask
  task automatic t_program;
    logic b6;
    cmd3(8'ha0);
    wr(19'h00012, 8'h3c, 3);
    chkBusy(1);
    rd(19'h00012);
    chk("poll7", {7'h0, rv[7]}, 8'h01);
    b6 = rv[6];
    rd(19'h00040);
    chk("toggle6", {7'h0, rv[6]}, {7'h0, ~b6});
    cmd3(8'ha0);
    wr(19'h00013, 8'h00, 3);
    waitIdle;
    rd(19'h00012);
    chk("programmed", rv, 8'h3c);
    rd(19'h00012);
    chk("reread", rv, 8'h3c);
    rd(19'h00013);
    chk("ignored", rv, 8'hff);
  endtask
  task automatic t_erase;
    erase(8'h30, 19'h00012);
    chkBusy(1);
    chk("sectorKind", {5'h0, eraseKindSeen}, 8'h01);
    rd(19'h00012);
    chk("erase7", {7'h0, rv[7]}, 8'h00);
    waitIdle;
    rd(19'h00012);
    chk("erased", rv, 8'hff);
    erase(8'h50, 19'h10000);
    chkBusy(1);
    chk("blockKind", {5'h0, eraseKindSeen}, 8'h02);
    waitIdle;
    erase(8'h10, U1);
    chkBusy(1);
    chk("chipKind", {5'h0, eraseKindSeen}, 8'h04);
    waitIdle;
    parallelProgrammingMode <= 0;
    repeat (4) @(posedge clk);
    erase(8'h10, U1);
    chkBusy(0);
    parallelProgrammingMode <= 1;
    repeat (4) @(posedge clk);
  endtask
  task automatic t_refuse;
    cmd3(8'h77);
    wr(19'h00020, 8'h00, 3);
    chkBusy(0);
    cmd3(8'ha0);
    wr(19'h00020, 8'h00, 1);
    chkBusy(0);
    wr(19'h00021, 8'h55, 3);
    chkBusy(1);
    waitIdle;
    outputGate_n <= 0;
    cmd3(8'ha0);
    wr(19'h00022, 8'h00, 3);
    chkBusy(0);
    outputGate_n <= 1;
  endtask
  task automatic t_ident;
    cmd3(8'h90);
    chk("idMode", {7'h0, idMode}, 8'h01);
    rd(19'h00000);
    chk("maker", rv, 8'h5a);
    rd(19'h00001);
    chk("device", rv, 8'ha5);
    wr(19'h00300, 8'hf0, 3);
    chk("idExit1", {7'h0, idMode}, 8'h00);
    rd(19'h00001);
    chk("arrayRead", rv, 8'hff);
    cmd3(8'h90);
    chk("idEntry2", {7'h0, idMode}, 8'h01);
    cmd3(8'hf0);
    chk("idExit3", {7'h0, idMode}, 8'h00);
  endtask
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      fails++;
      print_verdict;
    end
  end
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 0;
    repeat (3) @(posedge clk);
    t_program;
    t_erase;
    t_refuse;
    t_ident;
    print_verdict;
  end
endmodule
